// ===== verilog/mipi_lane_pkg.sv
package mipi_lane_pkg;
	localparam int WORD_BITS = 8;
	localparam logic [2:0] BIT_CNT_RESET = 3'h0;
	localparam logic [2:0] BIT_CNT_LAST = 3'h7;
	localparam logic [7:0] WORD_RESET = 8'h00;
	localparam logic [3:0] SER_DIV_RESET = 4'h0;
	localparam int SER_DIV_DEFAULT = 2;
	localparam logic [1:0] BUF_ENTRIES = 2'h2;
	localparam logic [1:0] BUF_CNT_RESET = 2'h0;

	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_LOAD = 2'b01,
		SER_SHIFT = 2'b11
	} ser_state_e;
endpackage

// ===== verilog/mipi_lane_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mipi_lane_if;
	import mipi_lane_pkg::*;
	logic parallel_clk;
	logic serial_clk;
	logic [WORD_BITS-1:0] highspeed_tx_word;
	logic highspeed_out_en;
	logic lane_rst;
	logic lowpower_pos_out_en;
	logic lowpower_pos_tx_bit;
	logic lowpower_pos_rx_bit;
	logic lowpower_neg_out_en;
	logic lowpower_neg_tx_bit;
	logic lowpower_neg_rx_bit;

	modport lane(
		input parallel_clk, serial_clk, highspeed_tx_word, highspeed_out_en, lane_rst,
		input lowpower_pos_out_en, lowpower_pos_tx_bit, lowpower_neg_out_en,
		input lowpower_neg_tx_bit,
		output lowpower_pos_rx_bit, lowpower_neg_rx_bit
	);
	modport ctrl(
		output parallel_clk, serial_clk, highspeed_tx_word, highspeed_out_en, lane_rst,
		output lowpower_pos_out_en, lowpower_pos_tx_bit, lowpower_neg_out_en,
		output lowpower_neg_tx_bit,
		input lowpower_pos_rx_bit, lowpower_neg_rx_bit
	);
endinterface
`default_nettype wire

// ===== verilog/mipi_tx_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module mipi_tx_ctrl
	import mipi_lane_pkg::*;
#(
	parameter int SER_DIV = SER_DIV_DEFAULT
) (
	input wire logic clk,
	input wire logic sys_rst,
	mipi_lane_if.ctrl link,
	input wire logic [WORD_BITS-1:0] word_data,
	input wire logic word_valid,
	output logic word_ready,
	input wire logic hs_enable,
	input wire logic lane_reset_req,
	input wire logic lp_pos_en,
	input wire logic lp_pos_bit,
	input wire logic lp_neg_en,
	input wire logic lp_neg_bit,
	output logic lp_pos_sense,
	output logic lp_neg_sense
);
	typedef struct packed {
		logic [3:0] div_cnt;
		logic serial_clk;
		logic [2:0] bit_cnt;
		logic parallel_clk;
		logic [WORD_BITS-1:0] word;
		logic hs_en;
		logic rst;
		logic lp_pe, lp_pb, lp_ne, lp_nb;
		logic [1:0] ps_sync;
		logic [1:0] ns_sync;
	} state_s;
	state_s r, next_r;

	// Words are handed to the lane once per slow-clock period
	logic slow_fall;
	assign slow_fall = r.serial_clk && r.div_cnt == 4'(SER_DIV - 1) &&
		r.bit_cnt == 3'(BIT_CNT_LAST - 3'h4);
	assign word_ready = slow_fall;

	always_comb begin
		next_r = r;
		next_r.ps_sync = {r.ps_sync[0], link.lowpower_pos_rx_bit};
		next_r.ns_sync = {r.ns_sync[0], link.lowpower_neg_rx_bit};
		// Fast and slow clocks made here by divider (see R1)
		if (r.div_cnt == 4'(SER_DIV - 1)) begin
			next_r.div_cnt = SER_DIV_RESET;
			next_r.serial_clk = !r.serial_clk;
			if (r.serial_clk) begin
				next_r.bit_cnt = r.bit_cnt + 3'h1;
				if (r.bit_cnt == BIT_CNT_LAST)
					next_r.parallel_clk = 1'b1;
				else if (r.bit_cnt == 3'(BIT_CNT_LAST - 3'h4))
					next_r.parallel_clk = 1'b0;
			end
		end else begin
			next_r.div_cnt = r.div_cnt + 4'h1;
		end
		// Launch word with slow-clock falling edge (see R2)
		if (slow_fall) begin
			next_r.word = word_valid ? word_data : WORD_RESET;
			next_r.hs_en = hs_enable && word_valid; // see R3
			next_r.rst = lane_reset_req; // see R7
		end
		next_r.lp_pe = lp_pos_en; // see R4
		next_r.lp_pb = lp_pos_bit;
		next_r.lp_ne = lp_neg_en; // see R5
		next_r.lp_nb = lp_neg_bit;
		if (sys_rst)
			next_r = '0;
	end

	always_ff @(posedge clk) begin
		r <= next_r;
	end

	assign link.serial_clk = r.serial_clk;
	assign link.parallel_clk = r.parallel_clk;
	assign link.highspeed_tx_word = r.word;
	assign link.highspeed_out_en = r.hs_en;
	assign link.lane_rst = r.rst;
	assign link.lowpower_pos_out_en = r.lp_pe;
	assign link.lowpower_pos_tx_bit = r.lp_pb;
	assign link.lowpower_neg_out_en = r.lp_ne;
	assign link.lowpower_neg_tx_bit = r.lp_nb;
	assign lp_pos_sense = r.ps_sync[1];
	assign lp_neg_sense = r.ns_sync[1];
endmodule
`default_nettype wire

// ===== verilog/mipi_tx_lane.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - Fast and slow clocks reach every lane
// R2 - Eight-bit slow words serialized on fast clock
// R3 - High-speed driver on only while enabled
// R4 - Positive pad drives its low-power bit
// R5 - Negative pad drives its own low-power bit
// R6 - Sensed pad levels returned for reversible lanes
// R7 - Reset returns serializer idle, no stale bits
module mipi_tx_lane
	import mipi_lane_pkg::*;
#(
	parameter int WIDTH = WORD_BITS
) (
	input wire logic clk,
	input wire logic sys_rst,
	mipi_lane_if.lane link,
	input wire logic pad_pos_in,
	input wire logic pad_neg_in,
	output logic pad_pos_out,
	output logic pad_pos_oe_n,
	output logic pad_neg_out,
	output logic pad_neg_oe_n,
	output logic hs_active
);
	typedef struct packed {
		// Clock sampling
		logic [1:0] slow_sync;
		logic [1:0] fast_sync;
		logic slow_prev;
		logic fast_prev;

		// Two-entry word buffer
		logic [1:0][WIDTH-1:0] buf_data;
		logic [1:0] buf_hs;
		logic buf_rd;
		logic [1:0] buf_cnt;

		// Serializer
		ser_state_e state;
		logic [WIDTH-1:0] shift;
		logic [2:0] bit_cnt;
		logic shift_hs;

		// Low-power pins in from fabric, pad drive out
		logic [1:0] pe_sync;
		logic [1:0] pb_sync;
		logic [1:0] ne_sync;
		logic [1:0] nb_sync;
		logic pos_out;
		logic pos_oe_n;
		logic neg_out;
		logic neg_oe_n;
		// Pad levels back towards fabric
		logic [1:0] rxp_sync;
		logic [1:0] rxn_sync;
	} state_s;
	state_s r;
	state_s next_r;

	logic slow_rise;
	logic fast_rise;
	logic word_in;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_out_ready;
	logic take_word;
	logic hs_drive;
	logic hs_bit;
	logic [1:0] pos_lp;
	logic [1:0] neg_lp;

	// One synchroniser step; the pin enters the first flop
	function automatic logic [1:0] sync_step(input logic [1:0] stages, input logic pin);
		return {stages[0], pin};
	endfunction

	// Slot that the next accepted word fills
	function automatic logic buf_wr_slot(input logic rd, input logic [1:0] cnt);
		return rd ^ cnt[0];
	endfunction

	// Low-power level and active-low enable, from second flops only
	function automatic logic [1:0] lp_drive(input logic [1:0] en_s, input logic [1:0] bit_s);
		return {bit_s[1], !en_s[1]};
	endfunction

	// Second-stage synchronised clocks only; edges detected after
	assign slow_rise = r.slow_sync[1] && !r.slow_prev;
	assign fast_rise = r.fast_sync[1] && !r.fast_prev;

	// Words under lane reset are dropped, not buffered (see R7)
	assign word_in = slow_rise && !link.lane_rst;
	// Limitation: an overrun drops the newest word
	assign buf_in_ready = r.buf_cnt != BUF_ENTRIES;
	assign buf_out_valid = r.buf_cnt != BUF_CNT_RESET;
	// Shifter takes a word when idle or on its last bit
	assign buf_out_ready = fast_rise &&
		(r.state == SER_IDLE || (r.state == SER_SHIFT && r.bit_cnt == BIT_CNT_LAST));
	assign take_word = buf_out_valid && buf_out_ready;

	// Driver on only for a word that carried the enable
	assign hs_drive = r.state == SER_SHIFT && r.shift_hs;
	assign hs_bit = r.shift[0];
	assign pos_lp = lp_drive(r.pe_sync, r.pb_sync);
	assign neg_lp = lp_drive(r.ne_sync, r.nb_sync);

	always_comb begin
		next_r = r;
		// Pins and link clocks each pass two flops
		next_r.slow_sync = sync_step(r.slow_sync, link.parallel_clk);
		next_r.fast_sync = sync_step(r.fast_sync, link.serial_clk);
		next_r.pe_sync = sync_step(r.pe_sync, link.lowpower_pos_out_en);
		next_r.pb_sync = sync_step(r.pb_sync, link.lowpower_pos_tx_bit);
		next_r.ne_sync = sync_step(r.ne_sync, link.lowpower_neg_out_en);
		next_r.nb_sync = sync_step(r.nb_sync, link.lowpower_neg_tx_bit);
		next_r.rxp_sync = sync_step(r.rxp_sync, pad_pos_in);
		next_r.rxn_sync = sync_step(r.rxn_sync, pad_neg_in);
		next_r.slow_prev = r.slow_sync[1];
		next_r.fast_prev = r.fast_sync[1];

		// Capture on slow-clock rise; full refuses instead of overwriting (see R2)
		if (word_in && buf_in_ready) begin
			next_r.buf_data[buf_wr_slot(r.buf_rd, r.buf_cnt)] = link.highspeed_tx_word;
			next_r.buf_hs[buf_wr_slot(r.buf_rd, r.buf_cnt)] = link.highspeed_out_en;
		end
		next_r.buf_cnt = r.buf_cnt + 2'(word_in && buf_in_ready) - 2'(take_word);

		// Serializer, LSB first on fast clock (see R2)
		if (fast_rise) begin
			case (r.state)
				SER_IDLE: begin
					if (take_word) begin
						next_r.shift = r.buf_data[r.buf_rd];
						next_r.shift_hs = r.buf_hs[r.buf_rd];
						next_r.buf_rd = !r.buf_rd;
						next_r.bit_cnt = BIT_CNT_RESET;
						next_r.state = SER_SHIFT;
					end
				end
				SER_SHIFT: begin
					if (r.bit_cnt != BIT_CNT_LAST) begin
						next_r.shift = {1'b0, r.shift[WIDTH-1:1]};
						next_r.bit_cnt = r.bit_cnt + 3'h1;
					end else if (take_word) begin
						next_r.shift = r.buf_data[r.buf_rd];
						next_r.shift_hs = r.buf_hs[r.buf_rd];
						next_r.buf_rd = !r.buf_rd;
						next_r.bit_cnt = BIT_CNT_RESET;
						next_r.state = SER_SHIFT;
					end else begin
						next_r.state = SER_IDLE;
						next_r.shift_hs = 1'b0;
					end
				end
				default: begin
					// Unused encodings fall back to idle
					next_r.state = SER_IDLE;
					next_r.shift_hs = 1'b0;
				end
			endcase
		end

		// High-speed wins while enabled, else low-power per pad
		if (hs_drive) begin // see R3
			next_r.pos_out = hs_bit;
			next_r.neg_out = !hs_bit;
			next_r.pos_oe_n = 1'b0;
			next_r.neg_oe_n = 1'b0;
		end else begin
			next_r.pos_out = pos_lp[1]; // see R4
			next_r.pos_oe_n = pos_lp[0];
			next_r.neg_out = neg_lp[1]; // see R5
			next_r.neg_oe_n = neg_lp[0];
		end

		// Lane reset flushes buffer and shifter (see R7)
		// Flush wins over a word written on the same edge
		if (slow_rise && link.lane_rst) begin
			next_r.state = SER_IDLE;
			next_r.buf_cnt = BUF_CNT_RESET;
			next_r.shift = WORD_RESET;
			next_r.shift_hs = 1'b0;
		end

		// Pads released during system reset
		if (sys_rst) begin
			next_r = '0;
			next_r.pos_oe_n = 1'b1;
			next_r.neg_oe_n = 1'b1;
		end
	end

	// One register stage for all state
	always_ff @(posedge clk) begin
		r <= next_r;
	end

	// Pads registered, so a level lands one clock after the decision
	assign pad_pos_out = r.pos_out;
	assign pad_pos_oe_n = r.pos_oe_n;
	assign pad_neg_out = r.neg_out;
	assign pad_neg_oe_n = r.neg_oe_n;
	assign hs_active = hs_drive;
	assign link.lowpower_pos_rx_bit = r.rxp_sync[1]; // see R6
	assign link.lowpower_neg_rx_bit = r.rxn_sync[1]; // see R6
endmodule
`default_nettype wire

// ===== sim/mipi_tx_lane_serializer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mipi_tx_lane_serializer_checker
	import mipi_lane_pkg::*;
#(
	parameter int SER_DIV = SER_DIV_DEFAULT
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic parallel_clk,
	input wire logic serial_clk,
	input wire logic [WORD_BITS-1:0] highspeed_tx_word,
	input wire logic highspeed_out_en,
	input wire logic lane_rst
);
	logic p_prev, s_prev, seen, p_rise, s_rise;
	logic [7:0] clk_cnt;
	logic [3:0] bit_cnt;
	assign p_rise = parallel_clk & ~p_prev;
	assign s_rise = serial_clk & ~s_prev;
	// Counts start only after a first slow edge, the span before it is partial
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			p_prev <= 1'b0;
			s_prev <= 1'b0;
			seen <= 1'b0;
			clk_cnt <= 8'h00;
			bit_cnt <= 4'h0;
		end else begin
			p_prev <= parallel_clk;
			s_prev <= serial_clk;
			seen <= seen | p_rise;
			clk_cnt <= p_rise ? 8'h01 : clk_cnt + 8'h01;
			bit_cnt <= (p_rise ? 4'h0 : bit_cnt) + {3'h0, s_rise};
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Bench runs SER_DIV of 2, so a serial period is 4 clocks
	sequence serial_gap;
		!s_rise [*3];
	endsequence
	sequence serial_next;
		serial_gap ##1 s_rise;
	endsequence
	chk_serial_period: assert property (s_rise |=> serial_next)
		else $error("serial clock period wrong");
	chk_serial_duty: assert property (s_rise |-> serial_clk [*2] ##1 !serial_clk)
		else $error("serial clock duty wrong");
	chk_slow_period: assert property (p_rise && seen |-> clk_cnt == 8'(16 * SER_DIV))
		else $error("slow clock period wrong");
	chk_bits_per_word: assert property (p_rise && seen |-> bit_cnt == 4'h8)
		else $error("serial edges per word wrong");
	chk_word_holds: assert property (p_rise |-> $stable(highspeed_tx_word))
		else $error("word changed at slow edge");
	chk_enable_holds: assert property (p_rise |-> $stable(highspeed_out_en))
		else $error("enable changed at slow edge");
	chk_reset_holds: assert property (p_rise |-> $stable(lane_rst))
		else $error("lane reset changed at slow edge");
endmodule
`default_nettype wire

// ===== sim/mipi_tx_lane_serializer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mipi_tx_lane_serializer_tb_top;
	import mipi_lane_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b1, word_valid = 1'b0, hs_enable = 1'b0, lane_reset_req = 1'b0;
	logic lp_pos_en = 1'b0, lp_pos_bit = 1'b0, lp_neg_en = 1'b0, lp_neg_bit = 1'b0;
	logic ext_pos = 1'b1, ext_neg = 1'b1;
	logic [7:0] word_data = 8'h00;
	logic word_ready, lp_pos_sense, lp_neg_sense, pos_out, pos_oe_n, neg_out, neg_oe_n, hs_active;
	logic pad_pos, pad_neg;
	int miscompares = 0, comparisons = 0;
	mipi_lane_if link_i();
	// Pad level: lane when enabled, otherwise the far side
	assign pad_pos = pos_oe_n ? ext_pos : pos_out;
	assign pad_neg = neg_oe_n ? ext_neg : neg_out;
	mipi_tx_ctrl #(.SER_DIV(2)) mipi_tx_ctrl_i(.clk(clk), .sys_rst(sys_rst), .link(link_i),
		.word_data(word_data), .word_valid(word_valid), .word_ready(word_ready),
		.hs_enable(hs_enable), .lane_reset_req(lane_reset_req), .lp_pos_en(lp_pos_en),
		.lp_pos_bit(lp_pos_bit), .lp_neg_en(lp_neg_en), .lp_neg_bit(lp_neg_bit),
		.lp_pos_sense(lp_pos_sense), .lp_neg_sense(lp_neg_sense));
	mipi_tx_lane mipi_tx_lane_i(.clk(clk), .sys_rst(sys_rst), .link(link_i),
		.pad_pos_in(pad_pos), .pad_neg_in(pad_neg), .pad_pos_out(pos_out),
		.pad_pos_oe_n(pos_oe_n), .pad_neg_out(neg_out), .pad_neg_oe_n(neg_oe_n),
		.hs_active(hs_active));
	mipi_tx_lane_serializer_checker #(.SER_DIV(2)) mipi_tx_lane_serializer_checker_i(
		.clk(clk), .sys_rst(sys_rst), .parallel_clk(link_i.parallel_clk),
		.serial_clk(link_i.serial_clk), .highspeed_tx_word(link_i.highspeed_tx_word),
		.highspeed_out_en(link_i.highspeed_out_en), .lane_rst(link_i.lane_rst));
	always #50 clk = ~clk;
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic send(input logic [7:0] w);
		int n;
		@(posedge clk);
		word_data <= w;
		word_valid <= 1'b1;
		for (n = 0; n < 200 && word_ready !== 1'b1; n++) @(negedge clk);
		@(posedge clk);
		word_valid <= 1'b0;
	endtask
	// Quiet window: no high-speed shifting may appear
	task automatic expect_quiet(input int cycles);
		int n;
		for (n = 0; n < cycles; n++) begin
			@(negedge clk);
			if (hs_active !== 1'b0) check({7'h0, hs_active}, 8'h00);
		end
	endtask
	task automatic test_hs_word(input logic [7:0] w);
		int n;
		hs_enable <= 1'b1;
		send(w);
		for (n = 0; n < 300 && hs_active !== 1'b1; n++) @(negedge clk);
		repeat (2) @(negedge clk);
		check({7'h0, pos_oe_n | neg_oe_n}, 8'h00);
		for (n = 0; n < 8; n++) begin
			check({6'h0, pad_neg, pad_pos}, {6'h0, ~w[n], w[n]});
			repeat (4) @(negedge clk);
		end
		@(posedge clk);
		hs_enable <= 1'b0;
		$display("test_hs_word done");
	endtask
	task automatic test_hs_off;
		send(8'hff);
		expect_quiet(160);
		$display("test_hs_off done");
	endtask
	task automatic test_lowpower;
		logic [3:0] i;
		for (int k = 0; k < 16; k++) begin
			i = 4'(k);
			@(posedge clk);
			{lp_neg_bit, lp_neg_en, lp_pos_bit, lp_pos_en} <= i;
			{ext_neg, ext_pos} <= {~i[3], ~i[1]};
			repeat (16) @(negedge clk);
			check({6'h0, neg_oe_n, pos_oe_n}, {6'h0, ~i[2], ~i[0]});
			check({6'h0, pad_neg, pad_pos}, {6'h0, i[2] ~^ i[3], i[0] ~^ i[1]});
			check({6'h0, lp_neg_sense, lp_pos_sense}, {6'h0, pad_neg, pad_pos});
		end
		@(posedge clk);
		{lp_neg_en, lp_pos_en} <= 2'b00;
		$display("test_lowpower done");
	endtask
	task automatic test_lane_reset;
		hs_enable <= 1'b1;
		send(8'h5a);
		// Word sent with reset must never reach the pads
		lane_reset_req <= 1'b1;
		send(8'hc3);
		lane_reset_req <= 1'b0;
		hs_enable <= 1'b0;
		repeat (24) @(negedge clk);
		expect_quiet(120);
		$display("test_lane_reset done");
	endtask
	task automatic test_done;
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		test_hs_word(8'ha5);
		test_hs_word(8'h01);
		test_hs_off();
		test_lowpower();
		test_lane_reset();
		test_done();
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		test_done();
	end
endmodule
`default_nettype wire
